// *** design/mbf_core.sv ***
// decoder and executor for branch, move, bank and flag instructions
// assumes program memory answers prog_data_i combinationally for prog_addr_o,
// external data answers xdata_rdata_i while its read strobe stands
//
// What this block does
// - xor register into accumulator, one byte, one cycle
// - decrement register, jump in page when result nonzero, two cycles
// - jump on carry set or clear, else skip two bytes
// - jump on user flag zero or one set, else skip both bytes
// - jump when accumulator bit from opcode bits 7..5 is one
// - direct jump: opcode bits give pc 10..8, bank flop gives bit 11
// - page indirect jump loads low pc from byte at accumulator in page
// - jump when external interrupt input is low
// - four test input branches on low or high level, two cycles
// - jump on accumulator nonzero or zero
// - jump when timer flag is one
// - enable and disable the external interrupt input
// - enable clock output on test input zero pin
// - clear or set program bank flop selecting lower or upper 2K
// - register bank select maps registers to 0..7 or 24..31
// - immediate loads to accumulator, register or indirect memory
// - single cycle moves between accumulator, register and indirect memory
// - copy status word to accumulator and back
// - table reads from current page or page three into accumulator
// - external data read and write addressed by register zero or one
// - exchange accumulator with register, indirect memory, or low nibble
// - complement or clear carry and both user flags
// - register fields are plain binary register numbers
`timescale 1ns/100ps
module mbf_core (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] prog_data_i,
  input wire logic [7:0] xdata_rdata_i,
  input wire logic int_n_i,
  input wire logic test_input_zero_i,
  input wire logic test_input_one_i,
  input wire logic timer_flag_i,
  output logic [11:0] prog_addr_o,
  output mbf_pkg::mbf_xreq_t xdata_req_o,
  output logic [7:0] acc_o,
  output mbf_pkg::mbf_status_t status_o,
  output logic user_flag_one_o,
  output logic program_bank_flipflop_o,
  output logic ext_int_enable_o,
  output logic clock_output_enable_o,
  output logic timer_flag_clear_o,
  output logic instr_done_o,
  output logic illegal_op_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  mbf_pkg::mbf_phase_t ph;
  mbf_pkg::mbf_phase_t next_ph;
  logic mc;
  logic [11:0] pc;
  logic [7:0] op;
  logic [7:0] byte2;
  logic [7:0] reg_val;
  logic [7:0] ind_val;
  logic [7:0] ram_rdata;
  logic [5:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [11:0] next_pc;
  logic [7:0] next_acc;
  mbf_pkg::mbf_status_t next_st;
  logic next_uf1;
  logic next_pbank;
  logic next_int_en;
  logic next_clk_en;
  logic next_tclr;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire xor_reg = op[7:3] == mbf_pkg::PAT_XOR_REG;
  wire xor_ind = op[7:1] == mbf_pkg::PAT_XOR_IND;
  wire dec_jump = op[7:3] == mbf_pkg::PAT_DEC_JUMP;
  wire acc_bit_jump = op[4:0] == mbf_pkg::LOW_ACC_BIT_JUMP;
  wire direct_jump = op[4:0] == mbf_pkg::LOW_DIRECT_JUMP;
  wire page_jump = op == mbf_pkg::OP_PAGE_JUMP;
  wire reg_imm = op[7:3] == mbf_pkg::PAT_REG_IMM;
  wire ind_imm = op[7:1] == mbf_pkg::PAT_IND_IMM;
  wire acc_imm = op == mbf_pkg::OP_LOAD_A_IMM;
  wire a_from_reg = op[7:3] == mbf_pkg::PAT_A_FROM_REG;
  wire reg_from_a = op[7:3] == mbf_pkg::PAT_REG_FROM_A;
  wire a_from_ind = op[7:1] == mbf_pkg::PAT_A_FROM_IND;
  wire ind_from_a = op[7:1] == mbf_pkg::PAT_IND_FROM_A;
  wire xd_rd = op[7:1] == mbf_pkg::PAT_XDATA_RD;
  wire xd_wr = op[7:1] == mbf_pkg::PAT_XDATA_WR;
  wire xch_reg = op[7:3] == mbf_pkg::PAT_XCH_REG;
  wire xch_ind = op[7:1] == mbf_pkg::PAT_XCH_IND;
  wire nib_xch = op[7:1] == mbf_pkg::PAT_NIB_XCH;
  wire table_cur = op == mbf_pkg::OP_TABLE_READ;
  wire table_p3 = op == mbf_pkg::OP_TABLE_READ_P3;
  wire st_to_a = op == mbf_pkg::OP_STATUS_TO_A;
  wire a_to_st = op == mbf_pkg::OP_A_TO_STATUS;
  wire timer_jump = op == mbf_pkg::OP_JUMP_TIMER;
  wire cond_jump = (op == mbf_pkg::OP_JUMP_CARRY) | (op == mbf_pkg::OP_JUMP_NO_CARRY) |
    (op == mbf_pkg::OP_JUMP_UF0) | (op == mbf_pkg::OP_JUMP_UF1) |
    (op == mbf_pkg::OP_JUMP_INT_LOW) | (op == mbf_pkg::OP_JUMP_TI0_LOW) |
    (op == mbf_pkg::OP_JUMP_TI1_LOW) | (op == mbf_pkg::OP_JUMP_TI0_HIGH) |
    (op == mbf_pkg::OP_JUMP_TI1_HIGH) | (op == mbf_pkg::OP_JUMP_ACC_NZ) |
    (op == mbf_pkg::OP_JUMP_ACC_Z) | timer_jump;
  wire cond_cy = ((op == mbf_pkg::OP_JUMP_CARRY) & status_o.cy) |
    ((op == mbf_pkg::OP_JUMP_NO_CARRY) & ~status_o.cy);
  wire cond_uf = ((op == mbf_pkg::OP_JUMP_UF0) & status_o.uf0) |
    ((op == mbf_pkg::OP_JUMP_UF1) & user_flag_one_o);
  wire cond_int = (op == mbf_pkg::OP_JUMP_INT_LOW) & ~int_n_i;
  wire cond_ti = ((op == mbf_pkg::OP_JUMP_TI0_LOW) & ~test_input_zero_i) |
    ((op == mbf_pkg::OP_JUMP_TI1_LOW) & ~test_input_one_i) |
    ((op == mbf_pkg::OP_JUMP_TI0_HIGH) & test_input_zero_i) |
    ((op == mbf_pkg::OP_JUMP_TI1_HIGH) & test_input_one_i);
  wire cond_acc = ((op == mbf_pkg::OP_JUMP_ACC_NZ) & (acc_o != 8'h00)) |
    ((op == mbf_pkg::OP_JUMP_ACC_Z) & (acc_o == 8'h00));
  wire cond_tf = timer_jump & timer_flag_i;
  wire cond_true = cond_cy | cond_uf | cond_int | cond_ti | cond_acc | cond_tf;
  // accumulator bit selected by opcode bits 7..5
  wire acc_bit_set = acc_o[op[7:5]];
  wire prog_second = page_jump | table_cur | table_p3;
  wire xdata_op = xd_rd | xd_wr;
  wire has_b2 = cond_jump | dec_jump | acc_bit_jump | direct_jump | reg_imm | ind_imm |
    acc_imm;
  wire two_cycle = has_b2 | prog_second | xdata_op;
  wire single_known = xor_reg | xor_ind | a_from_reg | reg_from_a | a_from_ind |
    ind_from_a | xch_reg | xch_ind | nib_xch | st_to_a | a_to_st |
    (op == mbf_pkg::OP_INT_EN) | (op == mbf_pkg::OP_INT_DIS) |
    (op == mbf_pkg::OP_CLK_OUT_EN) | (op == mbf_pkg::OP_PBANK_LO) |
    (op == mbf_pkg::OP_PBANK_HI) | (op == mbf_pkg::OP_RBANK_LO) |
    (op == mbf_pkg::OP_RBANK_HI) | (op == mbf_pkg::OP_CPL_CY) |
    (op == mbf_pkg::OP_CPL_UF0) | (op == mbf_pkg::OP_CPL_UF1) |
    (op == mbf_pkg::OP_CLR_CY) | (op == mbf_pkg::OP_CLR_UF0) |
    (op == mbf_pkg::OP_CLR_UF1);
  wire known = two_cycle | single_known;
  // execution point: last phase of the last machine cycle
  wire ex = (ph == mbf_pkg::PH_EXEC) & (mc == two_cycle);

  ////////////////////////////////////////////////////////////////////////////
  // data memory addressing
  // register field used as plain binary index
  // working register taken from the selected bank
  wire [5:0] bank_base = status_o.rbank ? mbf_pkg::RBANK1_BASE : mbf_pkg::RBANK0_BASE;
  wire [5:0] reg_addr_fetch = bank_base + {3'h0, prog_data_i[2:0]};
  wire [5:0] reg_addr_op = bank_base + {3'h0, op[2:0]};
  wire wr_ind = ind_imm | ind_from_a | xch_ind | nib_xch;
  wire wr_reg = dec_jump | reg_imm | reg_from_a | xch_reg;
  // phases: fetch reads register, reg reads pointer target, exec writes back
  assign ram_addr = (ph == mbf_pkg::PH_FETCH) ? reg_addr_fetch :
    (ph == mbf_pkg::PH_REG) ? ram_rdata[5:0] :
    (ph == mbf_pkg::PH_IND) ? reg_val[5:0] :
    (wr_ind ? reg_val[5:0] : reg_addr_op);
  assign ram_we = ce_i & ex & (wr_ind | wr_reg);
  wire [7:0] dec_val = reg_val - 8'h01;
  wire [7:0] status_in = {acc_o[7:4], 1'b1, acc_o[2:0]};
  // program address for the second machine cycle
  // page indirect and table reads address the current page
  // page three forced for the page three table read
  wire [11:0] mc1_addr = table_p3 ? {pc[11], mbf_pkg::TABLE_PAGE3, acc_o} :
    prog_second ? {pc[11:8], acc_o} : pc;
  mbf_data_ram u_ram (
    .sys_clk_i(sys_clk_i),
    .ce_i(ce_i),
    .addr_i(ram_addr),
    .we_i(ram_we),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase sequence
  always_comb
  begin
    case (ph)
      mbf_pkg::PH_FETCH: next_ph = mbf_pkg::PH_REG;
      mbf_pkg::PH_REG: next_ph = mbf_pkg::PH_IND;
      mbf_pkg::PH_IND: next_ph = mbf_pkg::PH_EXEC;
      mbf_pkg::PH_EXEC: next_ph = mbf_pkg::PH_FETCH;
      default: next_ph = mbf_pkg::PH_FETCH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution
  always_comb
  begin
    next_pc = pc;
    next_acc = acc_o;
    next_st = status_o;
    next_uf1 = user_flag_one_o;
    next_pbank = program_bank_flipflop_o;
    next_int_en = ext_int_enable_o;
    next_clk_en = clock_output_enable_o;
    next_tclr = 1'b0;
    ram_wdata = acc_o;
    // pc steps over opcode and second byte, taken or not
    if ((ph == mbf_pkg::PH_FETCH) && (!mc || has_b2))
      next_pc = pc + 12'h001;
    if (ex)
    begin
      // xor with register or indirect memory
      if (xor_reg || xor_ind)
        next_acc = acc_o ^ (xor_reg ? reg_val : ind_val);
      if (dec_jump)
        ram_wdata = dec_val;
      if (dec_jump && (dec_val != 8'h00))
        next_pc = {pc[11:8], byte2};
      // in-page branch on any true condition
      if (cond_jump && cond_true)
        next_pc = {pc[11:8], byte2};
      // timer flag consumed by its test
      if (cond_tf)
        next_tclr = 1'b1;
      if (acc_bit_jump && acc_bit_set)
        next_pc = {pc[11:8], byte2};
      // direct jump with bank flop on bit 11
      if (direct_jump)
        next_pc = {program_bank_flipflop_o, op[7:5], byte2};
      if (page_jump)
        next_pc = {pc[11:8], byte2};
      // external interrupt enable, opcode bit 4 disables
      if ((op == mbf_pkg::OP_INT_EN) || (op == mbf_pkg::OP_INT_DIS))
        next_int_en = ~op[4];
      if (op == mbf_pkg::OP_CLK_OUT_EN)
        next_clk_en = 1'b1;
      // program bank select from opcode bit 4
      if ((op == mbf_pkg::OP_PBANK_LO) || (op == mbf_pkg::OP_PBANK_HI))
        next_pbank = op[4];
      // register bank select from opcode bit 4
      if ((op == mbf_pkg::OP_RBANK_LO) || (op == mbf_pkg::OP_RBANK_HI))
        next_st.rbank = op[4];
      if (acc_imm)
        next_acc = byte2;
      if (reg_imm || ind_imm)
        ram_wdata = byte2;
      if (a_from_reg)
        next_acc = reg_val;
      if (a_from_ind)
        next_acc = ind_val;
      if (st_to_a)
        next_acc = status_o;
      if (a_to_st)
        next_st = status_in;
      if (table_cur || table_p3)
        next_acc = byte2;
      // external read data taken at the end of the strobe
      if (xd_rd)
        next_acc = xdata_rdata_i;
      // exchanges, old accumulator is the default write data
      if (xch_reg)
        next_acc = reg_val;
      if (xch_ind)
        next_acc = ind_val;
      if (nib_xch)
        next_acc = {acc_o[7:4], ind_val[3:0]};
      if (nib_xch)
        ram_wdata = {ind_val[7:4], acc_o[3:0]};
      // complement or clear carry and user flags
      if ((op == mbf_pkg::OP_CPL_CY) || (op == mbf_pkg::OP_CLR_CY))
        next_st.cy = (op == mbf_pkg::OP_CPL_CY) & ~status_o.cy;
      if ((op == mbf_pkg::OP_CPL_UF0) || (op == mbf_pkg::OP_CLR_UF0))
        next_st.uf0 = (op == mbf_pkg::OP_CPL_UF0) & ~status_o.uf0;
      if ((op == mbf_pkg::OP_CPL_UF1) || (op == mbf_pkg::OP_CLR_UF1))
        next_uf1 = (op == mbf_pkg::OP_CPL_UF1) & ~user_flag_one_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ph <= mbf_pkg::PH_FETCH;
      mc <= 1'b0;
      pc <= mbf_pkg::PC_RESET;
      prog_addr_o <= mbf_pkg::PC_RESET;
      op <= 8'h00;
      byte2 <= 8'h00;
      reg_val <= 8'h00;
      ind_val <= 8'h00;
    end
    else if (ce_i)
    begin
      ph <= next_ph;
      pc <= next_pc;
      if (ph == mbf_pkg::PH_FETCH && !mc)
        op <= prog_data_i;
      if (ph == mbf_pkg::PH_FETCH && mc)
        byte2 <= prog_data_i;
      if (ph == mbf_pkg::PH_REG && !mc)
        reg_val <= ram_rdata;
      if (ph == mbf_pkg::PH_IND && !mc)
        ind_val <= ram_rdata;
      if (ph == mbf_pkg::PH_EXEC)
      begin
        mc <= !mc && two_cycle;
        prog_addr_o <= ex ? next_pc : mc1_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state and outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      acc_o <= mbf_pkg::ACC_RESET;
      status_o <= mbf_pkg::STATUS_RESET;
      user_flag_one_o <= 1'b0;
      program_bank_flipflop_o <= 1'b0;
      ext_int_enable_o <= 1'b0;
      clock_output_enable_o <= 1'b0;
      timer_flag_clear_o <= 1'b0;
      instr_done_o <= 1'b0;
      illegal_op_o <= 1'b0;
      xdata_req_o <= '0;
    end
    else if (ce_i)
    begin
      acc_o <= next_acc;
      status_o <= next_st;
      user_flag_one_o <= next_uf1;
      program_bank_flipflop_o <= next_pbank;
      ext_int_enable_o <= next_int_en;
      clock_output_enable_o <= next_clk_en;
      timer_flag_clear_o <= next_tclr;
      instr_done_o <= ex;
      illegal_op_o <= ex && !known;
      // strobe spans the whole second machine cycle
      if (ph == mbf_pkg::PH_EXEC && !mc && xdata_op)
      begin
        xdata_req_o.rd <= xd_rd;
        xdata_req_o.wr <= xd_wr;
        xdata_req_o.addr <= reg_val;
        xdata_req_o.wdata <= acc_o;
      end
      else if (ex)
      begin
        xdata_req_o.rd <= 1'b0;
        xdata_req_o.wr <= 1'b0;
      end
    end
  end

endmodule : mbf_core

// *** design/mbf_pkg.sv ***
// package for the branch, move and flag decoder of an 8-bit controller core
// assumes a single 50 MHz clock with four clocks to one machine cycle
package mbf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and memory layout
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h08;
  localparam logic [5:0] RBANK0_BASE = 6'h00;
  localparam logic [5:0] RBANK1_BASE = 6'h18;
  localparam logic [2:0] TABLE_PAGE3 = 3'h3;
  localparam int CLOCKS_PER_MCYCLE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cy;
    logic ac;
    logic uf0;
    logic rbank;
    logic one;
    logic [2:0] sp;
  } mbf_status_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mbf_xreq_t;

  typedef enum logic [1:0] {PH_FETCH, PH_REG, PH_IND, PH_EXEC} mbf_phase_t;

  ////////////////////////////////////////////////////////////////////////////
  // opcode patterns with register, accumulator bit or address fields
  localparam logic [4:0] PAT_XOR_REG = 5'h1b;
  localparam logic [6:0] PAT_XOR_IND = 7'h68;
  localparam logic [4:0] PAT_DEC_JUMP = 5'h1d;
  localparam logic [4:0] LOW_ACC_BIT_JUMP = 5'h12;
  localparam logic [4:0] LOW_DIRECT_JUMP = 5'h04;
  localparam logic [4:0] PAT_REG_IMM = 5'h17;
  localparam logic [6:0] PAT_IND_IMM = 7'h58;
  localparam logic [4:0] PAT_A_FROM_REG = 5'h1f;
  localparam logic [4:0] PAT_REG_FROM_A = 5'h15;
  localparam logic [6:0] PAT_A_FROM_IND = 7'h78;
  localparam logic [6:0] PAT_IND_FROM_A = 7'h50;
  localparam logic [6:0] PAT_XDATA_RD = 7'h40;
  localparam logic [6:0] PAT_XDATA_WR = 7'h48;
  localparam logic [4:0] PAT_XCH_REG = 5'h05;
  localparam logic [6:0] PAT_XCH_IND = 7'h10;
  localparam logic [6:0] PAT_NIB_XCH = 7'h18;

  ////////////////////////////////////////////////////////////////////////////
  // fixed opcodes
  localparam logic [7:0] OP_JUMP_CARRY = 8'hf6;
  localparam logic [7:0] OP_JUMP_NO_CARRY = 8'he6;
  localparam logic [7:0] OP_JUMP_UF0 = 8'hb6;
  localparam logic [7:0] OP_JUMP_UF1 = 8'h76;
  localparam logic [7:0] OP_JUMP_INT_LOW = 8'h86;
  localparam logic [7:0] OP_JUMP_TI0_LOW = 8'h26;
  localparam logic [7:0] OP_JUMP_TI1_LOW = 8'h46;
  localparam logic [7:0] OP_JUMP_TI0_HIGH = 8'h36;
  localparam logic [7:0] OP_JUMP_TI1_HIGH = 8'h56;
  localparam logic [7:0] OP_JUMP_ACC_NZ = 8'h96;
  localparam logic [7:0] OP_JUMP_ACC_Z = 8'hc6;
  localparam logic [7:0] OP_JUMP_TIMER = 8'h16;
  localparam logic [7:0] OP_PAGE_JUMP = 8'hb3;
  localparam logic [7:0] OP_INT_EN = 8'h05;
  localparam logic [7:0] OP_INT_DIS = 8'h15;
  localparam logic [7:0] OP_CLK_OUT_EN = 8'h75;
  localparam logic [7:0] OP_PBANK_LO = 8'he5;
  localparam logic [7:0] OP_PBANK_HI = 8'hf5;
  localparam logic [7:0] OP_RBANK_LO = 8'hc5;
  localparam logic [7:0] OP_RBANK_HI = 8'hd5;
  localparam logic [7:0] OP_LOAD_A_IMM = 8'h23;
  localparam logic [7:0] OP_STATUS_TO_A = 8'hc7;
  localparam logic [7:0] OP_A_TO_STATUS = 8'hd7;
  localparam logic [7:0] OP_TABLE_READ = 8'ha3;
  localparam logic [7:0] OP_TABLE_READ_P3 = 8'he3;
  localparam logic [7:0] OP_CPL_CY = 8'ha7;
  localparam logic [7:0] OP_CPL_UF0 = 8'h95;
  localparam logic [7:0] OP_CPL_UF1 = 8'hb5;
  localparam logic [7:0] OP_CLR_CY = 8'h97;
  localparam logic [7:0] OP_CLR_UF0 = 8'h85;
  localparam logic [7:0] OP_CLR_UF1 = 8'ha5;

endpackage : mbf_pkg

// *** design/mbf_data_ram.sv ***
// 64-byte internal data memory holding both register banks
// assumes one port: read data registered, write when we_i is high
`timescale 1ns/100ps
module mbf_data_ram (
  input wire logic sys_clk_i,
  input wire logic ce_i,
  input wire logic [5:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [64];

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
        mem[addr_i] <= wdata_i;
      rdata_o <= mem[addr_i];
    end
  end

endmodule : mbf_data_ram

// *** verification/mbf_core_sva.sv ***
// concurrent checks on the ports of the branch, move and flag decoder
// assumes ce_i held high and back-to-back instructions, done marks each fetch edge
`timescale 1ns/100ps
module mbf_core_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] prog_data_i,
  input wire logic timer_flag_i,
  input wire logic [11:0] prog_addr_o,
  input wire mbf_pkg::mbf_xreq_t xdata_req_o,
  input wire mbf_pkg::mbf_status_t status_o,
  input wire logic program_bank_flipflop_o,
  input wire logic ext_int_enable_o,
  input wire logic clock_output_enable_o,
  input wire logic timer_flag_clear_o,
  input wire logic instr_done_o
);
  default clocking chk_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  a_int_enable_set: assert property (
    instr_done_o && prog_data_i == mbf_pkg::OP_INT_EN |-> ##4 instr_done_o && ext_int_enable_o)
    else $error("interrupt enable not set");
  a_clock_out_set: assert property (
    instr_done_o && prog_data_i == mbf_pkg::OP_CLK_OUT_EN |-> ##4 clock_output_enable_o)
    else $error("clock output enable not set");
  a_prog_bank_sel: assert property (
    instr_done_o && (prog_data_i == mbf_pkg::OP_PBANK_LO || prog_data_i == mbf_pkg::OP_PBANK_HI)
    |-> ##4 program_bank_flipflop_o == $past(prog_data_i[4], 4))
    else $error("program bank flop wrong");
  a_reg_bank_sel: assert property (
    instr_done_o && (prog_data_i == mbf_pkg::OP_RBANK_LO || prog_data_i == mbf_pkg::OP_RBANK_HI)
    |-> ##4 status_o.rbank == $past(prog_data_i[4], 4))
    else $error("register bank select wrong");
  a_carry_cpl_flip: assert property (
    instr_done_o && prog_data_i == mbf_pkg::OP_CPL_CY |-> ##4 status_o.cy != $past(status_o.cy, 4))
    else $error("carry not complemented");
  a_xdata_wr_strobe: assert property (
    instr_done_o && prog_data_i[7:1] == mbf_pkg::PAT_XDATA_WR
    |-> ##4 xdata_req_o.wr [*4] ##1 !xdata_req_o.wr && instr_done_o)
    else $error("external write strobe wrong");
  a_branch_two_cyc: assert property (
    instr_done_o && (prog_data_i == mbf_pkg::OP_JUMP_CARRY || prog_data_i == mbf_pkg::OP_JUMP_NO_CARRY)
    |-> ##1 !instr_done_o [*7] ##1 instr_done_o)
    else $error("carry branch not two cycles");
  a_direct_jump_addr: assert property (
    instr_done_o && prog_data_i[4:0] == mbf_pkg::LOW_DIRECT_JUMP |-> ##8 prog_addr_o ==
    {program_bank_flipflop_o, $past(prog_data_i[7:5], 8), $past(prog_data_i, 4)})
    else $error("direct jump target wrong");
  a_timer_clr_pulse: assert property (
    instr_done_o && prog_data_i == mbf_pkg::OP_JUMP_TIMER && timer_flag_i
    |-> ##[1:8] timer_flag_clear_o)
    else $error("timer flag clear missing");
endmodule : mbf_core_sva

bind mbf_core mbf_core_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .prog_data_i(prog_data_i), .timer_flag_i(timer_flag_i), .prog_addr_o(prog_addr_o),
  .xdata_req_o(xdata_req_o), .status_o(status_o),
  .program_bank_flipflop_o(program_bank_flipflop_o), .ext_int_enable_o(ext_int_enable_o),
  .clock_output_enable_o(clock_output_enable_o), .timer_flag_clear_o(timer_flag_clear_o),
  .instr_done_o(instr_done_o));

// *** verification/mbf_mem_model.sv ***
// program memory and external data memory beside the decoder
// assumes program bytes are loaded by the bench through pmem
`timescale 1ns/100ps
module mbf_mem_model (
  input wire logic sys_clk_i,
  input wire logic [11:0] prog_addr_i,
  input wire mbf_pkg::mbf_xreq_t xreq_i,
  output logic [7:0] prog_data_o,
  output logic [7:0] xdata_rdata_o
);
  logic [7:0] pmem [4096];
  logic [7:0] xmem [256];
  logic [7:0] last_rd = 8'h00;

  initial
  begin
    foreach (pmem[i])
      pmem[i] = 8'h00;
  end

  assign prog_data_o = pmem[prog_addr_i];
  // read answer, released bus shows inverse
  assign xdata_rdata_o = xreq_i.rd ? xmem[xreq_i.addr] : ~last_rd;

  always @(posedge sys_clk_i)
  begin
    if (xreq_i.rd)
      last_rd <= xmem[xreq_i.addr];
    if (xreq_i.wr)
      xmem[xreq_i.addr] <= xreq_i.wdata;
  end
endmodule : mbf_mem_model

// *** verification/tb_top.sv ***
// self-checking bench running a program through the decoder
// assumes the memory model answers fetches combinationally
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic int_n_i = 1'b1;
  logic test_input_zero_i = 1'b0;
  logic test_input_one_i = 1'b0;
  logic timer_flag_i = 1'b0;
  logic [11:0] prog_addr, a;
  logic [7:0] prog_data, xrdata, acc, v, w, r1, r2, rx, rv, t;
  mbf_pkg::mbf_xreq_t xreq;
  mbf_pkg::mbf_status_t status;
  logic uf1, pbf, int_en, clk_en, tf_clr, done, illegal;
  logic [5:0] cnd;
  logic [7:0] ops [6] = '{8'h26, 8'h46, 8'h36, 8'h56, 8'h86, 8'h16};
  logic [23:0] exp_q [$];
  logic [31:0] seed = 32'h75ef;
  int n_errors = 0;
  int samples_checked = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  mbf_core uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .prog_data_i(prog_data),
    .xdata_rdata_i(xrdata), .int_n_i(int_n_i), .test_input_zero_i(test_input_zero_i),
    .test_input_one_i(test_input_one_i), .timer_flag_i(timer_flag_i), .prog_addr_o(prog_addr),
    .xdata_req_o(xreq), .acc_o(acc), .status_o(status), .user_flag_one_o(uf1),
    .program_bank_flipflop_o(pbf), .ext_int_enable_o(int_en), .clock_output_enable_o(clk_en),
    .timer_flag_clear_o(tf_clr), .instr_done_o(done), .illegal_op_o(illegal));
  mbf_mem_model u_mem (.sys_clk_i(sys_clk_i), .prog_addr_i(prog_addr), .xreq_i(xreq),
    .prog_data_o(prog_data), .xdata_rdata_o(xrdata));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  function automatic logic [23:0] ex(input int c, input int p, input logic [7:0] d);
    return {c[3:0], p[11:0], d};
  endfunction : ex

  task automatic put(input logic [11:0] ad, input logic [7:0] b [$]);
    foreach (b[i])
      u_mem.pmem[ad + 12'(i)] = b[i];
  endtask : put

  task automatic ck(input logic [11:0] got, input logic [11:0] want, input string what);
    samples_checked++;
    if (got !== want)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : ck

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // one instruction: length in clocks, next fetch address, accumulator
  task automatic step(input logic [23:0] x, input bit chk_len);
    int n;
    logic [11:0] fa;
    n = 0;
    fa = prog_addr;
    @(negedge sys_clk_i);
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (done !== 1'b1)
    begin
      ck(12'h000, 12'h001, "timeout");
      test_done();
    end
    if (chk_len)
      ck(12'(n + 1), {8'h00, x[23:20]}, "length");
    ck(prog_addr, x[19:8], "pc");
    ck({4'h0, acc}, {4'h0, x[7:0]}, "acc");
    ck({11'h000, illegal}, {11'h000, u_mem.pmem[fa] == 8'h00}, "no-op flag");
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    v = rnd();
    w = rnd();
    r1 = rnd();
    r2 = rnd();
    rv = rnd();
    t = rnd();
    rx = 8'h20 | (t & 8'h1f);
    t = rnd();
    test_input_zero_i <= t[0];
    test_input_one_i <= t[1];
    int_n_i <= t[2];
    timer_flag_i <= 1'b1;
    cnd = {1'b1, ~t[2], t[1], t[0], ~t[1], ~t[0]};
    put(12'h000, '{8'h23, v, 8'hab, 8'h23, w, 8'hdb, 8'hd5, 8'hbb, 8'h02, 8'hc5, 8'hfb, 8'hd5,
      8'heb, 8'h10, 8'h00, 8'h00, 8'heb, 8'h13, 8'hfb, 8'h96, 8'h20, 8'hc6, 8'h20});
    put(12'h020, '{8'h97, 8'hf6, 8'h40, 8'ha7, 8'hf6, 8'h26, 8'he6, 8'h40, 8'h23, 8'h80, 8'hf2,
      8'h2e, 8'h00, 8'h00, 8'h12, 8'h40, 8'h95, 8'hb6, 8'h35, 8'h00, 8'h00, 8'h85, 8'hb6,
      8'h40, 8'hb5, 8'h76, 8'h3d, 8'h00, 8'h00, 8'ha5, 8'h05, 8'h15, 8'h75});
    put(12'h059, '{8'h23, 8'hf0, 8'ha3, 8'he3, 8'h23, 8'he0, 8'hb3});
    put(12'h070, '{8'hf5, 8'h64, 8'h00});
    put(12'h0e0, '{8'h70});
    put(12'h0f0, '{r1});
    put({4'h3, r1}, '{r2});
    put(12'hb00, '{8'he5, 8'h23, rx, 8'ha8, 8'h23, rv, 8'h90, 8'h23, 8'h00, 8'h80, 8'h28,
      8'h28, 8'ha0, 8'h23, 8'h0f, 8'h30, 8'h20, 8'hc7, 8'h23, 8'h20, 8'hd7});
    exp_q = {ex(8,'h002,v), ex(4,'h003,v), ex(8,'h005,w), ex(4,'h006,w^v), ex(4,'h007,w^v),
      ex(8,'h009,w^v), ex(4,'h00a,w^v), ex(4,'h00b,v), ex(4,'h00c,v), ex(8,'h010,v),
      ex(8,'h012,v), ex(4,'h013,0), ex(8,'h015,0), ex(8,'h020,0), ex(4,'h021,0), ex(8,'h023,0),
      ex(4,'h024,0), ex(8,'h026,0), ex(8,'h028,0), ex(8,'h02a,'h80), ex(8,'h02e,'h80),
      ex(8,'h030,'h80), ex(4,'h031,'h80), ex(8,'h035,'h80), ex(4,'h036,'h80), ex(8,'h038,'h80),
      ex(4,'h039,'h80), ex(8,'h03d,'h80), ex(4,'h03e,'h80), ex(4,'h03f,'h80), ex(4,'h040,'h80),
      ex(4,'h041,'h80)};
    for (int k = 0; k < 6; k++)
    begin
      a = 12'h041 + 12'(4 * k);
      put(a, '{ops[k], a[7:0] + 8'h04, 8'h00, 8'h00});
      if (cnd[k])
        exp_q.push_back(ex(8, a + 4, 'h80));
      else
        exp_q = {exp_q, ex(8, a + 2, 'h80), ex(4, a + 3, 'h80), ex(4, a + 4, 'h80)};
    end
    exp_q = {exp_q, ex(8,'h05b,'hf0), ex(8,'h05c,r1), ex(8,'h05d,r2), ex(8,'h05f,'he0),
      ex(8,'h070,'he0), ex(4,'h071,'he0), ex(8,'hb00,'he0), ex(4,'hb01,'he0), ex(8,'hb03,rx),
      ex(4,'hb04,rx), ex(8,'hb06,rv), ex(8,'hb07,rv), ex(8,'hb09,0), ex(8,'hb0a,rv),
      ex(4,'hb0b,rx), ex(4,'hb0c,rv), ex(4,'hb0d,rv), ex(8,'hb0f,'h0f), ex(4,'hb10,rv & 'h0f),
      ex(4,'hb11,rv | 'h0f), ex(4,'hb12,'h98), ex(8,'hb14,'h20), ex(4,'hb15,'h20)};
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    ck(prog_addr, mbf_pkg::PC_RESET, "reset pc");
    ck({4'h0, acc}, {4'h0, mbf_pkg::ACC_RESET}, "reset acc");
    ck({4'h0, status}, {4'h0, mbf_pkg::STATUS_RESET}, "reset status");
    ck({8'h00, uf1, pbf, int_en, clk_en}, 12'h000, "reset flags");
    foreach (exp_q[i])
      step(exp_q[i], i > 0);
    ck({4'h0, u_mem.xmem[rx]}, {4'h0, rv}, "external write");
    ck({4'h0, status}, 12'h028, "status write");
    ck({8'h00, uf1, pbf, int_en, clk_en}, 12'h001, "final flags");
    test_done();
  end
endmodule : tb_top
